/* File: core/external_trigger_handshake.sv */
// trigger-link handshake: external trigger in, measurement complete out
// Functional notes
// - link input, digital pin and manual key each start a reading in external mode
// - select key toggles between waiting for trigger and continuous readings
// - while waiting, trigger indicator lit and reading display blanked to dashes
// - each manual key press while waiting in local yields exactly one reading
// - link line one is completion output, line two the trigger input
// - digital pin and link input are one node, handled identically
// - interlock low disables input triggers; open or high enables them
// - trigger recognised on falling edge of input pulse
// - input pulses act only when external source is configured
// - after measurement ends, one completion pulse is driven
// - after the completion pulse, return to waiting for next trigger
// - per trigger: take reading, store it, then send output pulse
// - link pulse, key press or bus trigger satisfy the external event wait
// - manual key ignored under remote control, honoured in local
// - output trigger only after measurement, filtering and channel switching end
`timescale 1ns/1ps
module external_trigger_handshake
    import trig_link_pkg::*;
#(
    parameter int COMPLETE_CYC = trig_link_pkg::COMPLETE_PULSE_CYC,
    parameter int MIN_IN_CYC = trig_link_pkg::TRIG_IN_MIN_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // trigger link and digital i/o pins
    input wire logic trig_link_in_i,
    input wire logic interlock_i,
    output logic measurement_complete_output_o,
    // front panel
    input wire logic external_trigger_select_key_i,
    input wire logic manual_trigger_key_i,
    output logic trigger_indicator_o,
    output logic display_dashes_o,
    // remote interface, same clock
    input wire logic remote_i,
    input wire logic bus_trigger_i,
    // measurement engine, same clock
    output logic measure_start_o,
    input wire logic measure_done_i,
    output logic store_reading_o,
    input wire logic store_done_i
);
    import trig_link_pkg::*;

    typedef enum {
        ST_CONT,
        ST_WAIT,
        ST_MEASURE,
        ST_STORE,
        ST_PULSE
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic ext_mode;
        logic [2:0] sel_sync;
        logic [1:0] il_sync;
        logic [CNT_W-1:0] pulse_cnt;
        logic complete;
        logic start;
        logic store;
    } state_type;

    state_type st;
    state_type next_st;
    logic link_fall;
    logic key_fall;
    logic sel_press;
    logic trig_event;

    // pin and key edges share one filter each; the link and digital pin are one wire
    edge_sync #(.MIN_LOW(MIN_IN_CYC), .IDLE_LEVEL(1'b1)) u_link_edge (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .raw_i(trig_link_in_i),
        .fall_o(link_fall)
    );

    // keys are active high; invert so a press is a falling edge
    edge_sync #(.MIN_LOW(1), .IDLE_LEVEL(1'b1)) u_key_edge (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .raw_i(~manual_trigger_key_i),
        .fall_o(key_fall)
    );

    assign sel_press = st.sel_sync[1] & ~st.sel_sync[2];

    always_comb
    begin
        trig_event = (link_fall & st.il_sync[1])
            | (key_fall & ~remote_i)
            | bus_trigger_i;
    end

    always_comb
    begin
        next_st = st;
        next_st.sel_sync = {st.sel_sync[1:0], external_trigger_select_key_i};
        next_st.il_sync = {st.il_sync[0], interlock_i};
        next_st.start = 1'b0;
        next_st.store = 1'b0;
        next_st.complete = 1'b0;
        case (st.phase)
            ST_CONT:
            begin
                if (sel_press)
                begin
                    next_st.ext_mode = 1'b1;
                    next_st.phase = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (sel_press)
                begin
                    next_st.ext_mode = 1'b0;
                    next_st.phase = ST_CONT;
                end
                else if (trig_event && st.ext_mode)
                begin
                    next_st.start = 1'b1;
                    next_st.phase = ST_MEASURE;
                end
            end
            ST_MEASURE:
            begin
                // done covers filtering and channel switching as well
                if (measure_done_i)
                begin
                    next_st.store = 1'b1;
                    next_st.phase = ST_STORE;
                end
            end
            ST_STORE:
            begin
                if (store_done_i)
                begin
                    next_st.complete = 1'b1;
                    next_st.pulse_cnt = CNT_W'(COMPLETE_CYC - 1);
                    next_st.phase = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                if (st.pulse_cnt == '0)
                begin
                    next_st.phase = ST_WAIT;
                end
                else
                begin
                    next_st.complete = 1'b1;
                    next_st.pulse_cnt = st.pulse_cnt - CNT_W'(1);
                end
            end
            default:
            begin
                next_st.phase = ST_CONT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st <= '{phase: ST_CONT, ext_mode: RESET_EXT_MODE, sel_sync: 3'h0, il_sync: 2'h3,
                    pulse_cnt: '0, complete: 1'b0, start: 1'b0, store: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // completion line idles high; pulse is active low like the trigger input
    assign measurement_complete_output_o = ~st.complete;
    assign trigger_indicator_o = st.ext_mode;
    assign display_dashes_o = (st.phase == ST_WAIT);
    assign measure_start_o = st.start;
    assign store_reading_o = st.store;

    sequence s_store_then_pulse;
        store_reading_o ##[1:1000] !measurement_complete_output_o;
    endsequence

    a_one_start_per: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        measure_start_o |=> !measure_start_o [*2]) else $error("double start");
    a_store_after_meas: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st.phase == ST_MEASURE && measure_done_i) |=> store_reading_o)
        else $error("store not after measure");
    a_pulse_after_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(measurement_complete_output_o) |-> $past(st.phase) == ST_STORE)
        else $error("pulse not after store");
    a_pulse_width: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(measurement_complete_output_o) |-> !measurement_complete_output_o [*2])
        else $error("completion pulse too short");
    a_interlock_block: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st.phase == ST_WAIT && !st.il_sync[1] && !key_fall && !bus_trigger_i && !sel_press)
        |=> !measure_start_o) else $error("trigger taken under interlock");
    a_remote_key: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st.phase == ST_WAIT && remote_i && key_fall && !link_fall && !bus_trigger_i
        && !sel_press) |=> !measure_start_o) else $error("key honoured in remote");
    a_cont_no_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !st.ext_mode |=> !measure_start_o) else $error("start outside external mode");
    a_return_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(measurement_complete_output_o) |-> display_dashes_o)
        else $error("no return to waiting");
    a_dash_indicator: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        display_dashes_o |-> trigger_indicator_o) else $error("dashes without lamp");
    a_order_seq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        store_reading_o |-> s_store_then_pulse) else $error("no pulse after store");
    a_link_taken: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st.phase == ST_WAIT && link_fall && st.il_sync[1] && !sel_press)
        |=> measure_start_o)
        else $error("link trigger not taken");
    a_select_arms: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st.phase == ST_CONT && sel_press)
        |=> (trigger_indicator_o && display_dashes_o))
        else $error("select key did not arm waiting");
endmodule : external_trigger_handshake

/* File: core/trig_link_pkg.sv */
// constants for the trigger-link handshake block
package trig_link_pkg;
    localparam int CLK_FREQ_HZ = 100_000_000;
    // least input pulse width, ns
    localparam int TRIG_IN_MIN_NS = 2000;
    localparam int TRIG_IN_MIN_CYC = (TRIG_IN_MIN_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    // completion pulse width, ns
    localparam int COMPLETE_PULSE_NS = 10000;
    localparam int COMPLETE_PULSE_CYC = (COMPLETE_PULSE_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
    localparam int CNT_W = 16;
    localparam logic RESET_EXT_MODE = 1'b0;
endpackage : trig_link_pkg

/* File: core/edge_sync.sv */
// two-stage synchroniser with falling-edge pulse and low-width filter
`timescale 1ns/1ps
module edge_sync #(
    parameter int MIN_LOW = 1,
    parameter logic IDLE_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // raw level and detected edge
    input wire logic raw_i,
    output logic fall_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic [15:0] low_cnt;
        logic armed;
        logic fall;
    } state_type;

    state_type st;
    state_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.meta = raw_i;
        next_st.sync = st.meta;
        next_st.fall = 1'b0;
        if (st.sync)
        begin
            next_st.low_cnt = '0;
            next_st.armed = 1'b1;
        end
        else if (st.armed)
        begin
            // one pulse per low phase, only once it is wide enough
            if (st.low_cnt >= 16'(MIN_LOW - 1))
            begin
                next_st.fall = 1'b1;
                next_st.armed = 1'b0;
            end
            else
            begin
                next_st.low_cnt = st.low_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st <= '{meta: IDLE_LEVEL, sync: IDLE_LEVEL, low_cnt: 16'h0000, armed: 1'b0,
                    fall: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign fall_o = st.fall;

    a_single_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fall_o |=> !fall_o) else $error("edge pulse longer than one cycle");
endmodule : edge_sync

/* File: sim/scanner_model.sv */
// behavioural external scanner on the far side of the trigger link
`timescale 1ns/1ps
module scanner_model #(
    parameter int SETTLE = 6,
    parameter int PULSE = 5
) (
    // clock
    input wire logic clk_sys_i,
    // link lines
    input wire logic complete_i,
    output logic channel_ready_o,
    // test control
    input wire logic step_i,
    output int channel_o
);
    // link line idles high through its pull-up
    initial channel_ready_o = 1'b1;
    initial channel_o = 0;
    // relay settles before channel-ready pulse goes out
    always
    begin
        @(posedge clk_sys_i);
        if (step_i)
        begin
            repeat (SETTLE) @(posedge clk_sys_i);
            channel_ready_o <= 1'b0;
            repeat (PULSE) @(posedge clk_sys_i);
            channel_ready_o <= 1'b1;
        end
    end
    // next channel on each completion pulse
    always @(negedge complete_i)
        channel_o <= channel_o + 1;
endmodule : scanner_model

/* File: sim/testbench.sv */
// self-checking bench for the trigger-link handshake block
`timescale 1ns/1ps
module testbench;
    localparam int CC = 4;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic link, interlock = 1'b1, complete, sel = 1'b0, key = 1'b0, ind, dash;
    logic remote = 1'b0, bus_trig = 1'b0, start, mdone = 1'b0, store, sdone = 1'b0;
    logic step = 1'b0;
    int chan;
    int fail_count = 0;
    int checked = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    external_trigger_handshake #(.COMPLETE_CYC(CC), .MIN_IN_CYC(3)) external_trigger_handshake_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .trig_link_in_i(link), .interlock_i(interlock),
        .measurement_complete_output_o(complete), .external_trigger_select_key_i(sel),
        .manual_trigger_key_i(key), .trigger_indicator_o(ind), .display_dashes_o(dash),
        .remote_i(remote), .bus_trigger_i(bus_trig), .measure_start_o(start),
        .measure_done_i(mdone), .store_reading_o(store), .store_done_i(sdone));
    scanner_model scanner_model_i (.clk_sys_i(clk_sys_i), .complete_i(complete),
        .channel_ready_o(link), .step_i(step), .channel_o(chan));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic wait_start(output logic got);
        int n;
        got = 1'b0;
        for (n = 0; n < 40 && got !== 1'b1; n++)
        begin
            @(posedge clk_sys_i);
            #1;
            if (start === 1'b1)
                got = 1'b1;
        end
    endtask : wait_start
    // finish one reading and time the completion pulse
    task automatic finish_meas;
        int n;
        int c0;
        c0 = chan;
        @(posedge clk_sys_i);
        mdone <= 1'b1;
        @(posedge clk_sys_i);
        mdone <= 1'b0;
        #1;
        check(store, 1'b1);
        check(complete, 1'b1);
        @(posedge clk_sys_i);
        sdone <= 1'b1;
        @(posedge clk_sys_i);
        sdone <= 1'b0;
        #1;
        n = 0;
        while (complete === 1'b0 && n < 50)
        begin
            n++;
            @(posedge clk_sys_i);
            #1;
        end
        check(n, CC);
        @(posedge clk_sys_i);
        #1;
        check(dash, 1'b1);
        check(chan, c0 + 1);
    endtask : finish_meas
    task automatic press_select(input logic exp_ind);
        @(posedge clk_sys_i);
        sel <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sel <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1;
        check(ind, exp_ind);
        check(dash, exp_ind);
    endtask : press_select
    task automatic scan_step(input logic exp);
        logic got;
        @(posedge clk_sys_i);
        step <= 1'b1;
        @(posedge clk_sys_i);
        step <= 1'b0;
        wait_start(got);
        check(got, exp);
        if (got === 1'b1)
            finish_meas();
    endtask : scan_step
    task automatic key_press(input logic exp);
        logic got;
        @(posedge clk_sys_i);
        key <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        key <= 1'b0;
        wait_start(got);
        check(got, exp);
        if (got === 1'b1)
            finish_meas();
        wait_start(got);
        check(got, 1'b0);
    endtask : key_press
    task automatic bus_step;
        @(posedge clk_sys_i);
        bus_trig <= 1'b1;
        @(posedge clk_sys_i);
        bus_trig <= 1'b0;
        #1;
        check(start, 1'b1);
        finish_meas();
    endtask : bus_step
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        check(complete, 1'b1);
        check(ind, 1'b0);
        press_select(1'b1);
        scan_step(1'b1);
        scan_step(1'b1);
        @(posedge clk_sys_i);
        interlock <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        scan_step(1'b0);
        @(posedge clk_sys_i);
        interlock <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        key_press(1'b1);
        @(posedge clk_sys_i);
        remote <= 1'b1;
        key_press(1'b0);
        bus_step();
        @(posedge clk_sys_i);
        remote <= 1'b0;
        key_press(1'b1);
        press_select(1'b0);
        scan_step(1'b0);
        summarize();
    end
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule : testbench
